// ===== logic/opc_pkg.sv
// Purpose: shared constants and types of the optic control and status block
// Assumes: 200 MHz system clock
// Notes: times keep their printed figures; cycle counts derive from them
package opc_pkg;

    localparam int              CW     = 36;           // wide enough for the cooled start-up count
    localparam longint unsigned CLK_HZ = 200_000_000;

    // times in their own units
    localparam longint unsigned T_TON_MS       = 2;
    localparam longint unsigned T_2W_MS        = 300;
    localparam longint unsigned T_START_MS     = 300;
    localparam longint unsigned T_START_COOL_S = 90;
    localparam longint unsigned T_PL2_UP_MS    = 300;
    localparam longint unsigned T_PL2_DN_MS    = 300;
    localparam longint unsigned T_RESET_US     = 10;
    localparam longint unsigned T_RS_FC_US     = 500;
    localparam longint unsigned T_RS_NFC_MS    = 10;

    // longest times round down, least times round up
    localparam logic [CW-1:0] TON_CYC        = CW'(T_TON_MS * CLK_HZ / 1000);
    localparam logic [CW-1:0] T2W_CYC        = CW'(T_2W_MS * CLK_HZ / 1000);
    localparam logic [CW-1:0] START_CYC      = CW'(T_START_MS * CLK_HZ / 1000);
    localparam logic [CW-1:0] START_COOL_CYC = CW'(T_START_COOL_S * CLK_HZ);
    localparam logic [CW-1:0] PL2_UP_CYC     = CW'(T_PL2_UP_MS * CLK_HZ / 1000);
    localparam logic [CW-1:0] PL2_DN_CYC     = CW'(T_PL2_DN_MS * CLK_HZ / 1000);
    localparam logic [CW-1:0] RS_FC_CYC      = CW'(T_RS_FC_US * CLK_HZ / 1_000_000);
    localparam logic [CW-1:0] RS_NFC_CYC     = CW'(T_RS_NFC_MS * CLK_HZ / 1000);
    localparam logic [11:0]   RESET_CYC      = 12'((T_RESET_US * CLK_HZ + 999_999) / 1_000_000);

    // register byte offsets
    localparam logic [7:0] REG_CTRL     = 8'h00;
    localparam logic [7:0] REG_STATUS   = 8'h04;
    localparam logic [7:0] REG_INT_STAT = 8'h08;
    localparam logic [7:0] REG_INT_MASK = 8'h0C;
    localparam logic [7:0] REG_MON      = 8'h10;
    localparam logic [7:0] REG_CAL_GAIN = 8'h14;
    localparam logic [7:0] REG_CAL_OFF  = 8'h18;

    // control bit positions
    localparam int CTRL_PL2    = 0;
    localparam int CTRL_COOLED = 1;
    localparam int CTRL_FC     = 2;
    localparam int CTRL_W      = 3;

    // event bit positions
    localparam int EV_FAULT  = 0;
    localparam int EV_LOS    = 1;
    localparam int EV_OPER   = 2;
    localparam int EV_RATE   = 3;
    localparam int EV_PL2    = 4;
    localparam int NEV       = 5;

    // values after reset
    localparam logic [CTRL_W-1:0] CTRL_RST = 3'h0;
    localparam logic [NEV-1:0]    MASK_RST = 5'h00;
    localparam logic [15:0]       GAIN_RST = 16'h0100;   // unity, 8 fraction bits
    localparam logic [15:0]       OFF_RST  = 16'h0000;
    localparam int                GAIN_FRAC = 8;

    typedef enum logic [1:0] {
        ST_START = 2'b00,
        ST_RUN   = 2'b01,
        ST_FAULT = 2'b11
    } opc_state_t;

    typedef struct packed {
        logic txDisable;
        logic rateSelLow;
        logic rateSelHigh;
        logic sigPresent;
        logic laserFault;
    } opc_pins_t;

endpackage

// ===== logic/opc_ctrl.sv
// Purpose: control and status timing of a hot-pluggable optic, registers on AHB-Lite
// Assumes: pin inputs are asynchronous to clk; raw monitor sample is synchronous
// Notes: every device delay is a cycle count kept at or under its limit
// Contract
// - monitor reading is reported already calibrated by internal gain and offset
// - optical output goes off within 100 us of transmitter-off rising
// - in normal operation output returns within 2 ms of transmitter-off falling
// - management interface ready within 300 ms of power-on
// - uncooled part fully operational within 300 ms of start or recovery
// - cooled part fully operational within 90 s of start or recovery
// - power level two reached within 300 ms of the enabling write
// - back within power level one within 300 ms of the disabling write
// - uncooled part flags a laser fault within 1 ms
// - cooled part flags a laser fault within 50 ms
// - transmitter-off held high at least 10 us resets a latched fault
// - fibre channel rate select gives stable output within 500 us
// - other rate select gives stable output within 10 ms
// - signal-lost output asserts within 100 us of signal loss
// - signal-lost output negates within 100 us of signal return
`timescale 1ns/1ps
module opc_ctrl #(
    parameter logic [opc_pkg::CW-1:0] TON_LIM        = opc_pkg::TON_CYC,
    parameter logic [opc_pkg::CW-1:0] T2W_LIM        = opc_pkg::T2W_CYC,
    parameter logic [opc_pkg::CW-1:0] START_LIM      = opc_pkg::START_CYC,
    parameter logic [opc_pkg::CW-1:0] START_COOL_LIM = opc_pkg::START_COOL_CYC,
    parameter logic [opc_pkg::CW-1:0] PL2_UP_LIM     = opc_pkg::PL2_UP_CYC,
    parameter logic [opc_pkg::CW-1:0] PL2_DN_LIM     = opc_pkg::PL2_DN_CYC,
    parameter logic [opc_pkg::CW-1:0] RS_FC_LIM      = opc_pkg::RS_FC_CYC,
    parameter logic [opc_pkg::CW-1:0] RS_NFC_LIM     = opc_pkg::RS_NFC_CYC
) (
    input  wire logic              clk,         // 200 MHz clock
    input  wire logic              reset_n,     // async reset, active low
    input  wire logic              hsel,        // slave select
    input  wire logic [31:0]       haddr,       // byte address
    input  wire logic [1:0]        htrans,      // transfer type
    input  wire logic              hwrite,      // write when high
    input  wire logic [2:0]        hsize,       // word only
    input  wire logic [31:0]       hwdata,      // write data
    input  wire logic              hready,      // bus ready
    output logic [31:0]            hrdata,      // read data
    output logic                   hreadyout,   // always ready
    output logic                   hresp,       // always okay
    input  wire opc_pkg::opc_pins_t pinsIn,     // asynchronous control pins
    input  wire logic [15:0]       monRaw,      // raw monitor sample
    output logic                   laserEnable, // optical output on
    output logic                   txFaultOut,  // open drain data, always low
    output logic                   txFaultOe,   // pulls low while no fault
    output logic                   rxLos,       // signal lost
    output logic                   mgmtReady,   // management link ready
    output logic                   operational, // fully operational
    output logic                   rateStable,  // rate select settled
    output logic                   pl2Active,   // running at power level two
    output logic                   irq          // level interrupt
);
    import opc_pkg::*;

    localparam logic [CW-1:0] ONE = CW'(1);

    opc_pins_t        syncA_reg;
    opc_pins_t        syncB_reg;
    logic             txDisPrev_reg;
    logic [1:0]       rsPrev_reg;
    logic [11:0]      disHighCnt_reg;
    opc_state_t       state_reg;
    opc_state_t       state_next;
    logic [CW-1:0]    startCnt_reg;
    logic [CW-1:0]    tonCnt_reg;
    logic [CW-1:0]    twCnt_reg;
    logic [CW-1:0]    rsCnt_reg;
    logic [CW-1:0]    plCnt_reg;
    logic             laser_reg;
    logic             faultOe_reg;
    logic             los_reg;
    logic             mgmt_reg;
    logic             rateStable_reg;
    logic             pl2_reg;
    logic [CTRL_W-1:0] ctrl_reg;
    logic [NEV-1:0]   intStat_reg;
    logic [NEV-1:0]   intMask_reg;
    logic [15:0]      gain_reg;
    logic [15:0]      off_reg;
    logic [15:0]      mon_reg;
    logic [31:0]      hrdata_reg;
    logic             wrPend_reg;
    logic [7:0]       wrAddr_reg;

    logic             txDis;
    logic             txDisFall;
    logic             resetPulse;
    logic             faultIn;
    logic [CW-1:0]    startLim;
    logic [CW-1:0]    rsLim;
    logic [CW-1:0]    plLim;
    logic             rsRise;
    logic [NEV-1:0]   events;
    logic [31:0]      monProd;
    logic             addrPhase;
    logic [31:0]      rdMux;
    logic [31:0]      statusWord;

    // two flip-flops before any logic reads a pin
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            syncA_reg <= '{txDisable: 1'b1, default: 1'b0}; // an open pin idles high, so no start-up count
            syncB_reg <= '{txDisable: 1'b1, default: 1'b0};
        end else begin
            syncA_reg <= pinsIn;
            syncB_reg <= syncA_reg;
        end
    end

    // an open transmitter-off pin reads high through the board pull-up
    assign txDis      = syncB_reg.txDisable;
    assign faultIn    = syncB_reg.laserFault;
    assign txDisFall  = txDisPrev_reg && !txDis;
    assign resetPulse = txDisFall && (disHighCnt_reg >= RESET_CYC);
    assign rsRise     = (syncB_reg.rateSelLow && !rsPrev_reg[0]) ||
                        (syncB_reg.rateSelHigh && !rsPrev_reg[1]);

    // variant and mode selected by software
    assign startLim = ctrl_reg[CTRL_COOLED] ? START_COOL_LIM : START_LIM;
    assign rsLim    = ctrl_reg[CTRL_FC] ? RS_FC_LIM : RS_NFC_LIM;
    assign plLim    = ctrl_reg[CTRL_PL2] ? PL2_UP_LIM : PL2_DN_LIM;

    // edge history of the synchronised pins
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            txDisPrev_reg <= 1'b1;                               // matches the synchroniser reset level
            rsPrev_reg    <= 2'h0;
        end else begin
            txDisPrev_reg <= txDis;
            rsPrev_reg    <= {syncB_reg.rateSelHigh, syncB_reg.rateSelLow};
        end
    end

    // measures how long transmitter-off stays high; saturates to stay small
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            disHighCnt_reg <= 12'h000;
        end else if (!txDis) begin
            disHighCnt_reg <= 12'h000;
        end else if (disHighCnt_reg < RESET_CYC) begin
            disHighCnt_reg <= disHighCnt_reg + 12'h001;
        end
    end

    // fault is latched at once, well inside both flag limits
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_START: begin
                if (faultIn) begin
                    state_next = ST_FAULT;
                end else if (!txDis && startCnt_reg >= startLim) begin
                    state_next = ST_RUN;
                end
            end
            ST_RUN: begin
                if (faultIn) begin
                    state_next = ST_FAULT;
                end
            end
            ST_FAULT: begin
                if (resetPulse) begin
                    state_next = ST_START;
                end
            end
            default: state_next = ST_START;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= ST_START;
        end else begin
            state_reg <= state_next;
        end
    end

    // start-up timer; cleared while transmitter-off is high so it runs from its negation
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            startCnt_reg <= '0;
        end else if (state_reg != ST_START || txDis) begin
            startCnt_reg <= '0;
        end else if (startCnt_reg < startLim) begin
            startCnt_reg <= startCnt_reg + ONE;
        end
    end

    // turn-on delay after transmitter-off falls; preset at start-up exit so no wait then
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tonCnt_reg <= '0;
        end else if (state_reg != ST_RUN) begin
            tonCnt_reg <= TON_LIM;
        end else if (txDis) begin
            tonCnt_reg <= '0;
        end else if (tonCnt_reg < TON_LIM) begin
            tonCnt_reg <= tonCnt_reg + ONE;
        end
    end

    // laser drops in the cycle after the request is seen, far under the limit
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            laser_reg <= 1'b0;
        end else begin
            laser_reg <= (state_next == ST_RUN) && !txDis && (tonCnt_reg >= TON_LIM);
        end
    end

    // open drain fault: pulled low while healthy, released while latched
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            faultOe_reg <= 1'b1;
        end else begin
            faultOe_reg <= (state_next != ST_FAULT);
        end
    end

    // signal-lost follows the synchronised detector, three cycles late at most
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            los_reg <= 1'b1;
        end else begin
            los_reg <= !syncB_reg.sigPresent;
        end
    end

    // management link comes up once after reset
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            twCnt_reg <= '0;
            mgmt_reg  <= 1'b0;
        end else if (twCnt_reg < T2W_LIM) begin
            twCnt_reg <= twCnt_reg + ONE;
        end else begin
            mgmt_reg  <= 1'b1;
        end
    end

    // a rising edge on either rate select restarts settling
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rsCnt_reg      <= '0;
            rateStable_reg <= 1'b1;
        end else if (rsRise) begin
            rsCnt_reg      <= '0;
            rateStable_reg <= 1'b0;
        end else if (rsCnt_reg < rsLim) begin
            rsCnt_reg      <= rsCnt_reg + ONE;
        end else begin
            rateStable_reg <= 1'b1;
        end
    end

    // power level moves after its settle time; flipping back mid-way restarts
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            plCnt_reg <= '0;
            pl2_reg   <= 1'b0;
        end else if (ctrl_reg[CTRL_PL2] == pl2_reg) begin
            plCnt_reg <= '0;
        end else if (plCnt_reg >= plLim) begin
            plCnt_reg <= '0;
            pl2_reg   <= ctrl_reg[CTRL_PL2];
        end else begin
            plCnt_reg <= plCnt_reg + ONE;
        end
    end

    // calibration applied inside, so software reads engineering units
    assign monProd = monRaw * gain_reg;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mon_reg <= 16'h0000;
        end else begin
            mon_reg <= monProd[GAIN_FRAC+15:GAIN_FRAC] + off_reg;
        end
    end

    // events that feed the sticky status
    assign events[EV_FAULT] = (state_next == ST_FAULT) && (state_reg != ST_FAULT);
    assign events[EV_LOS]   = los_reg != !syncB_reg.sigPresent;
    assign events[EV_OPER]  = (state_next == ST_RUN) && (state_reg == ST_START);
    assign events[EV_RATE]  = !rateStable_reg && !rsRise && (rsCnt_reg >= rsLim);
    assign events[EV_PL2]   = (ctrl_reg[CTRL_PL2] != pl2_reg) && (plCnt_reg >= plLim);

    // ahb-lite: zero wait states, address captured for the write data phase
    assign addrPhase = hsel && htrans[1] && hready;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wrPend_reg <= 1'b0;
            wrAddr_reg <= 8'h00;
        end else begin
            wrPend_reg <= addrPhase && hwrite;
            wrAddr_reg <= haddr[7:0];
        end
    end

    // software settings
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_reg    <= CTRL_RST;
            intMask_reg <= MASK_RST;
            gain_reg    <= GAIN_RST;
            off_reg     <= OFF_RST;
        end else if (wrPend_reg) begin
            case (wrAddr_reg)
                REG_CTRL:     ctrl_reg    <= hwdata[CTRL_W-1:0];
                REG_INT_MASK: intMask_reg <= hwdata[NEV-1:0];
                REG_CAL_GAIN: gain_reg    <= hwdata[15:0];
                REG_CAL_OFF:  off_reg     <= hwdata[15:0];
                default:      ctrl_reg    <= ctrl_reg;
            endcase
        end
    end

    // sticky status, write one to clear; a new event beats the clear
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            intStat_reg <= '0;
        end else if (wrPend_reg && wrAddr_reg == REG_INT_STAT) begin
            intStat_reg <= (intStat_reg & ~hwdata[NEV-1:0]) | events;
        end else begin
            intStat_reg <= intStat_reg | events;
        end
    end

    assign statusWord = {22'h000000, state_reg, 1'b0, laser_reg, mgmt_reg, pl2_reg,
                         rateStable_reg, los_reg, !faultOe_reg, state_reg == ST_RUN};

    // read mux; unmapped offsets read zero
    always_comb begin
        case (haddr[7:0])
            REG_CTRL:     rdMux = {29'h00000000, ctrl_reg};
            REG_STATUS:   rdMux = statusWord;
            REG_INT_STAT: rdMux = {27'h0000000, intStat_reg};
            REG_INT_MASK: rdMux = {27'h0000000, intMask_reg};
            REG_MON:      rdMux = {16'h0000, mon_reg};
            REG_CAL_GAIN: rdMux = {16'h0000, gain_reg};
            REG_CAL_OFF:  rdMux = {16'h0000, off_reg};
            default:      rdMux = 32'h00000000;
        endcase
    end

    // read data sampled at the address phase, shown in the data phase
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            hrdata_reg <= 32'h00000000;
        end else if (addrPhase && !hwrite) begin
            hrdata_reg <= rdMux;
        end
    end

    assign hrdata      = hrdata_reg;
    assign hreadyout   = 1'b1;
    assign hresp       = 1'b0;
    assign laserEnable = laser_reg;
    assign txFaultOut  = 1'b0;
    assign txFaultOe   = faultOe_reg;
    assign rxLos       = los_reg;
    assign mgmtReady   = mgmt_reg;
    assign operational = (state_reg == ST_RUN);
    assign rateStable  = rateStable_reg;
    assign pl2Active   = pl2_reg;
    assign irq         = |(intStat_reg & intMask_reg);

    // checks
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    AST_LASER_OFF: assert property ($rose(txDis) |=> !laserEnable)
        else $error("laser still on after transmitter-off rose");
    AST_LASER_ON: assert property ($rose(laserEnable) |-> $past(tonCnt_reg) >= TON_LIM && !$past(txDis))
        else $error("laser on before turn-on delay");
    AST_MGMT: assert property ($rose(mgmtReady) |-> $past(twCnt_reg) == T2W_LIM)
        else $error("management ready at wrong count");
    AST_START: assert property ($rose(operational) && !$past(operational) |-> $past(startCnt_reg, 1) >= $past(startLim))
        else $error("operational before start-up time");
    AST_FAULT_FLAG: assert property (faultIn && state_reg != ST_FAULT |=> !txFaultOe)
        else $error("fault not flagged next cycle");
    AST_FAULT_HOLD: assert property (state_reg == ST_FAULT && !resetPulse |=> state_reg == ST_FAULT && !txFaultOe)
        else $error("fault released without reset pulse");
    AST_RESET_LEN: assert property ($fell(state_reg == ST_FAULT) |-> $past(disHighCnt_reg) >= RESET_CYC)
        else $error("fault cleared by short pulse");
    AST_LOS_ON: assert property (!syncB_reg.sigPresent |=> rxLos)
        else $error("signal-lost late");
    AST_LOS_OFF: assert property (syncB_reg.sigPresent ##1 syncB_reg.sigPresent |-> !rxLos)
        else $error("signal-lost not negated");
    AST_RATE: assert property (rsRise |=> !rateStable ##0 rsCnt_reg == '0)
        else $error("rate request not restarting settle");
    AST_PL2: assert property ($changed(pl2Active) |-> $past(plCnt_reg) >= $past(plLim))
        else $error("power level changed early");
    AST_MON: assert property (mon_reg == 16'($past(monProd) >> GAIN_FRAC) + $past(off_reg))
        else $error("monitor reading not calibrated");

    COV_FAULT_RECOVER: cover property (state_reg == ST_FAULT ##1 state_reg == ST_START);
    COV_LASER_CYCLE: cover property ($fell(laserEnable) ##[1:50] $rose(laserEnable));
    COV_PL2_UP: cover property ($rose(pl2Active));
    COV_IRQ: cover property ($rose(irq));

endmodule

// ===== verification/opc_host_model.sv
// Purpose: host board model driving the optic control pins
// Assumes: bench changes requests just after a rising edge
// Notes: stretch keeps transmitter-off high long enough to clear a fault
`timescale 1ns/1ps
module opc_host_model (
    input  wire logic          clk,     // bench clock
    input  wire logic          reset_n, // active low
    input  wire logic [4:0]    req,     // requested levels, pin order
    input  wire logic          stretch, // keep off pulses at the reset length
    output opc_pkg::opc_pins_t pins     // module control pins
);
    import opc_pkg::*;
    logic [11:0] holdCnt; // cycles of off pulse still owed
    // an open transmitter-off reads high, so that is the reset level
    // short pulses only when stretch is low, to try an invalid fault reset
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            holdCnt <= 12'h000;
            pins    <= opc_pins_t'(5'h12);
        end else begin
            holdCnt <= req[4] ? RESET_CYC : (holdCnt != 12'h000 ? holdCnt - 12'h001 : holdCnt);
            pins    <= opc_pins_t'(req | {stretch && holdCnt != 12'h000, 4'h0});
        end
    end
endmodule

// ===== verification/tb_pluggable_optic_control_status.sv
// Purpose: self-checking bench of the optic control and status block
// Assumes: shortened start, settle and rate counts set below
// Notes: expected values queue up; one watcher compares them in order
`timescale 1ns/1ps
module tb_pluggable_optic_control_status;
    import opc_pkg::*;
    logic        clk, reset_n, hsel, hwrite, stretch;
    logic [31:0] haddr, hwdata, hrdata, seen, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [15:0] monRaw;
    logic [4:0]  req;
    logic        hreadyout, hresp, laserEnable, txFaultOut, txFaultOe, rxLos;
    logic        mgmtReady, operational, rateStable, pl2Active, irq;
    opc_pins_t   pins;
    int          err_count, n_tests, seed;
    logic [31:0] expQ[$];
    event        chk;

    // shortened limits; the documented ones run to seconds
    localparam logic [CW-1:0] TB_TON    = 36'h14;
    localparam logic [CW-1:0] TB_2W     = 36'h32;
    localparam logic [CW-1:0] TB_START  = 36'h28;
    localparam logic [CW-1:0] TB_COOL   = 36'h3C;
    localparam logic [CW-1:0] TB_PL2    = 36'h1E;
    localparam logic [CW-1:0] TB_RS_FC  = 36'h0A;
    localparam logic [CW-1:0] TB_RS_NFC = 36'h19;

    opc_host_model i_opc_host_model (.clk(clk), .reset_n(reset_n), .req(req), .stretch(stretch), .pins(pins));
    opc_ctrl #(.TON_LIM(TB_TON), .T2W_LIM(TB_2W), .START_LIM(TB_START), .START_COOL_LIM(TB_COOL),
        .PL2_UP_LIM(TB_PL2), .PL2_DN_LIM(TB_PL2), .RS_FC_LIM(TB_RS_FC), .RS_NFC_LIM(TB_RS_NFC)) i_opc_ctrl (
        .clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .pinsIn(pins), .monRaw(monRaw), .laserEnable(laserEnable), .txFaultOut(txFaultOut),
        .txFaultOe(txFaultOe), .rxLos(rxLos), .mgmtReady(mgmtReady), .operational(operational),
        .rateStable(rateStable), .pl2Active(pl2Active), .irq(irq));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task end_of_test;
        if (err_count == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task check(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    // one ns gap so the watcher never misses a note
    task note(input logic [31:0] s, input logic [31:0] e);
        seen = s;
        expQ.push_back(e);
        -> chk;
        #1;
    endtask
    // settle just past the edge so registered outputs have landed
    task waitc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task pin(input logic s, input logic [4:0] r);
        @(posedge clk);
        stretch <= s;
        req     <= r;
    endtask
    // one AHB single transfer; read data lands in rd
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h000000, a};
        do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 50);
        htrans <= 2'h0; hwdata <= d;
        do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 50);
        rd = hrdata;
        if (n >= 50) begin err_count++; end_of_test(); end
        #1; // let the write land before anyone looks
    endtask
    task rdchk(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        note(rd, e);
    endtask

    // watcher: oldest expectation against the value just seen
    initial forever begin
        @(chk);
        check(seen, expQ.pop_front());
    end
    initial begin
        #400000;
        err_count++;
        end_of_test();
    end

    initial begin
        seed = 63; err_count = 0; n_tests = 0; hsel = 1'b0; htrans = 2'h0; hwrite = 1'b0; hsize = 3'h2;
        haddr = 32'h0; hwdata = 32'h0; req = 5'h02; stretch = 1'b1; monRaw = 16'h0000; reset_n = 1'b0;
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        // reset values, an unmapped place, then the start-up status word
        rdchk(REG_CAL_GAIN, 32'h100);
        rdchk(8'h40, 32'h0);
        waitc(60);
        rdchk(REG_STATUS, 32'h169);
        @(posedge clk);
        monRaw <= 16'($random(seed)) & 16'h3FFF;
        #1;
        rdchk(REG_MON, {16'h0000, monRaw});
        xfer(1'b1, REG_CAL_GAIN, 32'h200);
        xfer(1'b1, REG_CAL_OFF, 32'h11);
        rdchk(REG_MON, {16'h0000, (monRaw << 1) + 16'h0011});
        // signal lost and back
        pin(1'b1, 5'h00); waitc(4); note(rxLos, 1);
        pin(1'b1, 5'h02); waitc(4); note(rxLos, 0);
        // transmitter off and on in normal running
        pin(1'b1, 5'h12); waitc(4); note(laserEnable, 0);
        pin(1'b1, 5'h02); waitc(2040); note(laserEnable, 1);
        // rate settle, fibre channel then other mode, each checked before and after its limit
        xfer(1'b1, REG_CTRL, 32'h4);
        pin(1'b1, 5'h0A); waitc(5); note(rateStable, 0);
        waitc(15); note(rateStable, 1);
        xfer(1'b1, REG_CTRL, 32'h0);
        pin(1'b1, 5'h0E); waitc(20); note(rateStable, 0);
        waitc(15); note(rateStable, 1);
        // power level two up and down
        xfer(1'b1, REG_CTRL, 32'h1); waitc(20); note(pl2Active, 0);
        waitc(20); note(pl2Active, 1);
        xfer(1'b1, REG_CTRL, 32'h0); waitc(20); note(pl2Active, 1);
        waitc(20); note(pl2Active, 0);
        // fault latch, interrupt masking, short and valid reset pulses
        xfer(1'b1, REG_INT_STAT, 32'h1F);
        xfer(1'b1, REG_INT_MASK, 32'h1);
        pin(1'b1, 5'h03); waitc(5); note(txFaultOe, 0);
        note(irq, 1);
        pin(1'b1, 5'h02); waitc(10); note(laserEnable, 0);
        xfer(1'b1, REG_INT_MASK, 32'h0); note(irq, 0);
        xfer(1'b1, REG_INT_MASK, 32'h1); note(irq, 1);
        xfer(1'b1, REG_CTRL, 32'h2); // cooled variant for the recovery
        pin(1'b0, 5'h12); waitc(100); pin(1'b0, 5'h02); waitc(60); note(txFaultOe, 0);
        pin(1'b1, 5'h12); waitc(3); pin(1'b1, 5'h02); waitc(2050);
        note(operational, 0);
        waitc(20);
        note(txFaultOe, 1);
        note(operational, 1);
        xfer(1'b1, REG_INT_STAT, 32'h1); note(irq, 0);
        note(hresp, 0);
        note(txFaultOut, 0);
        note(mgmtReady, 1);
        waitc(2);
        check(expQ.size(), 0);
        end_of_test();
    end
endmodule
